//--- bench/tcr_config_regs_props.sv
`default_nettype none
module tcr_config_regs_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic rxBitValid,
  input wire logic [1:0] agcGainRequest,
  input wire logic lockPinOut,
  input wire logic lockPinOe,
  input wire logic txMode,
  input wire logic antennaTx,
  input wire logic [1:0] demodType,
  input wire logic demodTypeValid,
  input wire logic [2:0] lockMode,
  input wire logic syncDetectEnable,
  input wire logic demodLocked,
  input wire logic filterCalStart,
  input wire logic [1:0] lnaGain,
  input wire logic rssiReadbackValid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Received bits seen while the sync hit is shown
  logic [3:0] held;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) held <= 4'h0;
    else if (!lockPinOut || !syncDetectEnable) held <= 4'h0;
    else if (rxBitValid) held <= held + 4'h1;
  end
  a_antenna_tracks: assert property (antennaTx == txMode)
    else $error("antenna switch differs from direction");
  a_demod_code_ok: assert property (demodTypeValid == !demodType[1])
    else $error("demod type validity wrong");
  a_pin_owner: assert property (lockPinOe == (lockMode != 3'h4))
    else $error("lock pin drive wrong for mode");
  a_sync_mode_only: assert property (syncDetectEnable == (lockMode[2:1] == 2'h1))
    else $error("sync detect enable wrong for mode");
  a_sync_rise_bit: assert property ($rose(lockPinOut) && syncDetectEnable |-> $past(rxBitValid))
    else $error("sync hit without a received bit");
  a_sync_nine_bits: assert property (lockPinOut && syncDetectEnable |-> held < 4'h9)
    else $error("sync hit held past nine bits");
  a_gain_cap: assert property (lnaGain == 2'h3 |-> $past(agcGainRequest) == 2'h3)
    else $error("top gain step granted unasked");
  a_cal_one_cycle: assert property (filterCalStart |=> !filterCalStart)
    else $error("calibration start longer than one cycle");
  a_rssi_rx_only: assert property (rssiReadbackValid == !txMode)
    else $error("signal strength validity wrong");
  c_cal: cover property (filterCalStart);
  c_sync_hit: cover property ($rose(lockPinOut) && syncDetectEnable);
  c_timed_lock: cover property (demodLocked && lockMode == 3'h5);
endmodule : tcr_config_regs_props
bind tcr_config_regs tcr_config_regs_props u_props (.*);
`default_nettype wire

//--- bench/tcr_config_regs_tb.sv
`default_nettype none
module tcr_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [31:0] w;
    logic [24:0] e;
  } tcr_row_type;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic chipEnable = 1'b1;
  logic rxBit = 1'b0;
  logic rxBitValid = 1'b0;
  logic [1:0] agcGainRequest = 2'h0;
  logic lockPinIn = 1'b0;
  logic serialClock, serialDataIn, serialLatchStrobe, lockPinOut, lockPinOe;
  logic txMode, antennaTx, demodTypeValid, syncDetectEnable, demodLocked;
  logic sequencerTick, filterCalStart, rssiReadbackValid, auxReadbackValid;
  logic adcReadbackValid;
  logic [1:0] demodType, lnaGain;
  logic [2:0] lockMode;
  logic [6:0] gainLowLimit, gainHighLimit;
  logic [24:0] seen;
  int failures = 0;
  int totalChecks = 0;
  int cycles = 0;
  int calCount = 0;
  int tickCount = 0;
  // Seen: tx, antenna, type ok, mode, sync, pin drive, rssi, aux, adc, low, high
  tcr_row_type rows [12] = '{
    '{32'h08000000, {11'b11100001011, 14'hf46}},
    '{32'h00000408, {11'b11100001010, 14'hf46}},
    '{32'h00000000, {11'b00100001101, 14'hf46}},
    '{32'h000278f9, {11'b00100001111, 14'h7cf}},
    '{32'h000678f9, {11'b00100001101, 14'h7cf}},
    '{32'h01000014, {11'b00101011101, 14'h7cf}},
    '{32'h02000024, {11'b00010000101, 14'h7cf}},
    '{32'h01800034, {11'b00001111101, 14'h7cf}},
    '{32'h00800004, {11'b00100101101, 14'h7cf}},
    '{32'h02800004, {11'b00110101101, 14'h7cf}},
    '{32'h0000123a, {11'b00110101101, 14'h7cf}},
    '{32'hfffffffb, {11'b00110101101, 14'h7cf}}
  };
  assign seen = {txMode, antennaTx, demodTypeValid, lockMode, syncDetectEnable, lockPinOe,
    rssiReadbackValid, auxReadbackValid, adcReadbackValid, gainLowLimit, gainHighLimit};
  tcr_config_regs u_dut (.*);
  tcr_host_model u_host (.*);
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (filterCalStart === 1'b1) calCount++;
    if (sequencerTick === 1'b1) tickCount++;
    cycles++;
    if (cycles == 30000) begin
      failures++;
      test_done();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic settle;
    repeat (6) @(negedge ref_clk);
  endtask : settle
  task automatic put(input logic [31:0] w);
    u_host.send(w);
    settle();
  endtask : put
  task automatic rx_bit(input logic b);
    rxBit = b;
    rxBitValid = 1'b1;
    @(negedge ref_clk);
    rxBitValid = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask : rx_bit
  task automatic test_done;
    if (failures == 0 && totalChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    check("reset limits", {gainLowLimit, gainHighLimit}, 14'hf46);
    check("reset pins", {txMode, lockPinOe, lockPinOut}, 3'b010);
    foreach (rows[i]) begin
      put(rows[i].w);
      check("row outputs", rows[i].e, seen);
    end
    chipEnable = 1'b0;
    put(32'h08000000);
    check("dead port", 1'b0, txMode);
    chipEnable = 1'b1;
    settle();
    put(32'h0a5c33c5);
    put(32'h01000004);
    for (int i = 23; i > 0; i--) rx_bit(24'ha5c33c >> i);
    check("early hit", lockPinOut, 1'b0);
    rx_bit(1'b0);
    check("sync hit", lockPinOut, 1'b1);
    repeat (8) rx_bit(1'b0);
    check("hit after 8", lockPinOut, 1'b1);
    rx_bit(1'b0);
    check("hit after 9", lockPinOut, 1'b0);
    put(32'h00100003);
    put(32'h02ff8004);
    check("timed lock early", demodLocked, 1'b0);
    repeat (280) @(negedge ref_clk);
    check("timed lock", demodLocked, 1'b1);
    agcGainRequest = 2'h3;
    put(32'h00088006);
    check("cal pulses", calCount, 1);
    check("gain capped", lnaGain, 2'h2);
    put(32'h00000006);
    check("cal pulses idle", calCount, 1);
    check("gain full", lnaGain, 2'h3);
    put(32'h00400003);
    tickCount = 0;
    repeat (40) @(negedge ref_clk);
    check("seq ticks", 10, tickCount);
    put(32'h02000014);
    check("demod type", 2'h1, demodType);
    lockPinIn = 1'b1;
    repeat (4) @(negedge ref_clk);
    check("pin lock", 1'b1, demodLocked);
    check("pin not driven", 1'b0, lockPinOut);
    lockPinIn = 1'b0;
    repeat (4) @(negedge ref_clk);
    check("pin unlock", 1'b0, demodLocked);
    test_done();
  end
endmodule : tcr_config_regs_tb
`default_nettype wire

//--- bench/tcr_host_model.sv
`default_nettype none
module tcr_host_model (
  input wire logic ref_clk,
  output logic serialClock,
  output logic serialDataIn,
  output logic serialLatchStrobe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    serialClock = 1'b0;
    serialDataIn = 1'b0;
    serialLatchStrobe = 1'b0;
  end
  task automatic half_bit;
    repeat (10) @(negedge ref_clk);
  endtask : half_bit
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      serialDataIn = w[i];
      half_bit();
      serialClock = 1'b1;
      half_bit();
      serialClock = 1'b0;
    end
    half_bit();
    serialLatchStrobe = 1'b1;
    half_bit();
    serialLatchStrobe = 1'b0;
    // Released data line must not keep the last bit
    serialDataIn = ~serialDataIn;
  endtask : send
endmodule : tcr_host_model
`default_nettype wire

//--- core/dummy_end.sv
`default_nettype none
`default_nettype wire

//--- core/tcr_config_regs.sv
// Function
// - Tx/Rx bit sets operating direction and antenna switch state.
// - Demod type 00 linear, 01 correlator, other codes invalid.
// - Lock mode field selects one of six lock behaviours.
// - Sync word detection active only for lock modes 010 and 011.
// - In receive with sync detect, pattern match drives lock pin high.
// - Lock pin returns low after nine further received bits.
// - Mode 5 declares lock after threshold count sequencer periods.
// - Each write to register 6 (correlator) with calibration bit high starts filter calibration.
// - Reduced gain select forbids the highest front-end gain step.
// - Signal strength readback valid in receive; aux blocked with AGC in receive.
// - Transmit converter readback valid only with log amp powered.
// - Unwritten gain thresholds default to 30 low and 70 high.
// - Front-end gain 30 selectable only while reduced gain select is 0.
// - Words shift in MSB first, latch on strobe by low four bits.
// - Serial port inactive while chip enable is low.
`default_nettype none
`include "tcr_map.svh"
module tcr_config_regs (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic chipEnable,
  input wire logic serialClock,
  input wire logic serialDataIn,
  input wire logic serialLatchStrobe,
  input wire logic rxBit,
  input wire logic rxBitValid,
  input wire logic [1:0] agcGainRequest,
  input wire logic lockPinIn,
  output logic lockPinOut,
  output logic lockPinOe,
  output logic txMode,
  output logic antennaTx,
  output logic [1:0] demodType,
  output logic demodTypeValid,
  output logic [2:0] lockMode,
  output logic syncDetectEnable,
  output logic demodLocked,
  output logic sequencerTick,
  output logic filterCalStart,
  output logic [1:0] lnaGain,
  output logic rssiReadbackValid,
  output logic auxReadbackValid,
  output logic adcReadbackValid,
  output logic [6:0] gainLowLimit,
  output logic [6:0] gainHighLimit
);
  tcr_pkg::tcr_core_type st;
  tcr_pkg::tcr_core_type next_st;
  logic chipActive;
  logic wordStrobe;
  logic [31:0] word;

  function automatic logic isSyncMode(input logic [2:0] mode);
    isSyncMode = (mode == `TCR_MODE_SYNC_FREE) || (mode == `TCR_MODE_SYNC_LOCK);
  endfunction : isSyncMode

  function automatic logic isRx(input logic [31:0] nReg);
    isRx = !nReg[`TCR_TXRX_BIT];
  endfunction : isRx

  tcr_serial_port u_serial (
    .ref_clk(ref_clk),
    .rst(rst),
    .chipEnable(chipEnable),
    .serialClock(serialClock),
    .serialDataIn(serialDataIn),
    .serialLatchStrobe(serialLatchStrobe),
    .chipActive(chipActive),
    .wordStrobe(wordStrobe),
    .word(word)
  );

  always_comb begin
    logic [3:0] addr;
    logic [31:0] nReg;
    logic [31:0] demodReg;
    logic [31:0] corrReg;
    logic [31:0] agcReg;
    logic [7:0] seqDiv;
    logic [23:0] shifted;
    logic rxActive;
    logic demodWrite;
    logic match;
    addr = word[`TCR_ADDR_FIELD];
    next_st = st;
    next_st.filterCalStart = 1'b0;
    next_st.sequencerTick = 1'b0;
    next_st.extLockSync = {st.extLockSync[0], lockPinIn};
    demodWrite = 1'b0;
    if (wordStrobe && chipActive && addr <= `TCR_ADDR_LAST) begin
      next_st.bank[addr] = word;
      demodWrite = (addr == `TCR_ADDR_DEMOD);
      if (addr == `TCR_ADDR_CORR && word[`TCR_CAL_BIT]) begin
        next_st.filterCalStart = 1'b1;
      end
    end
    nReg = st.bank[`TCR_ADDR_N];
    demodReg = st.bank[`TCR_ADDR_DEMOD];
    corrReg = st.bank[`TCR_ADDR_CORR];
    agcReg = st.bank[`TCR_ADDR_AGC];
    seqDiv = st.bank[`TCR_ADDR_RXCLK][`TCR_SEQ_DIV];
    rxActive = isRx(nReg);

    next_st.txMode = !rxActive;
    next_st.antennaTx = !rxActive;
    next_st.demodType = demodReg[`TCR_DEMOD_TYPE];
    next_st.demodTypeValid = (demodReg[`TCR_DEMOD_TYPE] == `TCR_DEMOD_LINEAR) ||
                             (demodReg[`TCR_DEMOD_TYPE] == `TCR_DEMOD_CORR);
    next_st.lockMode = demodReg[`TCR_LOCK_MODE];
    next_st.syncDetectEnable = isSyncMode(demodReg[`TCR_LOCK_MODE]);
    next_st.gainLowLimit = agcReg[`TCR_AGC_LOW];
    next_st.gainHighLimit = agcReg[`TCR_AGC_HIGH];

    // Highest step is removed in reduced gain mode
    if (corrReg[`TCR_REDUCED_GAIN_SELECT_BIT] && agcGainRequest > `TCR_LNA_GAIN_CAP) begin
      next_st.lnaGain = `TCR_LNA_GAIN_CAP;
    end else begin
      next_st.lnaGain = agcGainRequest;
    end

    next_st.rssiReadbackValid = rxActive;
    next_st.auxReadbackValid = !(rxActive && agcReg[`TCR_AGC_ENABLE_BIT]);
    next_st.adcReadbackValid = rxActive ||
                               !st.bank[`TCR_ADDR_PWR][`TCR_LOGAMP_PD_BIT];

    // Sequencer divider; zero behaves as divide by one
    if (st.seqCount + `TCR_SEQ_ONE >= seqDiv) begin
      next_st.seqCount = 8'h00;
      next_st.sequencerTick = 1'b1;
    end else begin
      next_st.seqCount = st.seqCount + `TCR_SEQ_ONE;
    end

    // Sync pattern search, newest bit in the LSB
    shifted = {st.rxBits[22:0], rxBit};
    match = 1'b0;
    if (rxBitValid) begin
      next_st.rxBits = shifted;
      match = (shifted == st.bank[`TCR_ADDR_SYNC][`TCR_SYNC_WORD]) && rxActive &&
              isSyncMode(demodReg[`TCR_LOCK_MODE]);
    end
    unique case (st.syncState)
      tcr_pkg::SD_SEARCH: begin
        if (match) begin
          next_st.syncState = tcr_pkg::SD_HOLD;
          next_st.holdCount = 4'h0;
        end
      end
      tcr_pkg::SD_HOLD: begin
        if (rxBitValid) begin
          next_st.holdCount = st.holdCount + 4'h1;
          if (st.holdCount + 4'h1 == `TCR_SYNC_HOLD_BITS) begin
            next_st.syncState = tcr_pkg::SD_SEARCH;
          end
        end
      end
      default: begin
        next_st.syncState = tcr_pkg::SD_SEARCH;
      end
    endcase

    // Lock decision per mode
    unique case (demodReg[`TCR_LOCK_MODE])
      `TCR_MODE_SP_LOCK: next_st.demodLocked = 1'b1;
      `TCR_MODE_SYNC_LOCK: next_st.demodLocked = st.demodLocked || match;
      `TCR_MODE_PIN: next_st.demodLocked = st.extLockSync[1];
      `TCR_MODE_TIMED: begin
        if (st.lockCount == demodReg[`TCR_LOCK_COUNT]) begin
          next_st.demodLocked = 1'b1;
        end else if (st.sequencerTick) begin
          next_st.lockCount = st.lockCount + 8'h01;
        end
      end
      default: next_st.demodLocked = 1'b0;
    endcase
    if (demodWrite || !rxActive) begin
      next_st.lockCount = 8'h00;
      next_st.demodLocked = 1'b0;
      next_st.syncState = tcr_pkg::SD_SEARCH;
    end

    next_st.lockPinOe = (demodReg[`TCR_LOCK_MODE] != `TCR_MODE_PIN);
    if (isSyncMode(demodReg[`TCR_LOCK_MODE])) begin
      next_st.lockPinOut = (next_st.syncState == tcr_pkg::SD_HOLD);
    end else begin
      next_st.lockPinOut = next_st.demodLocked && next_st.lockPinOe;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.bank[`TCR_ADDR_AGC] <= `TCR_AGC_RESET;
      st.syncState <= tcr_pkg::SD_SEARCH;
      st.lockPinOe <= 1'b1;
      st.demodTypeValid <= 1'b1;
      st.rssiReadbackValid <= 1'b1;
      st.adcReadbackValid <= 1'b1;
      st.gainLowLimit <= `TCR_AGC_LOW_RESET;
      st.gainHighLimit <= `TCR_AGC_HIGH_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign lockPinOut = st.lockPinOut;
  assign lockPinOe = st.lockPinOe;
  assign txMode = st.txMode;
  assign antennaTx = st.antennaTx;
  assign demodType = st.demodType;
  assign demodTypeValid = st.demodTypeValid;
  assign lockMode = st.lockMode;
  assign syncDetectEnable = st.syncDetectEnable;
  assign demodLocked = st.demodLocked;
  assign sequencerTick = st.sequencerTick;
  assign filterCalStart = st.filterCalStart;
  assign lnaGain = st.lnaGain;
  assign rssiReadbackValid = st.rssiReadbackValid;
  assign auxReadbackValid = st.auxReadbackValid;
  assign adcReadbackValid = st.adcReadbackValid;
  assign gainLowLimit = st.gainLowLimit;
  assign gainHighLimit = st.gainHighLimit;
endmodule : tcr_config_regs
`default_nettype wire

//--- core/tcr_map.svh
`ifndef TCR_MAP_SVH
`define TCR_MAP_SVH
`define TCR_NUM_REGS 11
`define TCR_WORD_BITS 32
`define TCR_ADDR_FIELD 3:0
`define TCR_ADDR_N 4'h0
`define TCR_ADDR_RXCLK 4'h3
`define TCR_ADDR_DEMOD 4'h4
`define TCR_ADDR_SYNC 4'h5
`define TCR_ADDR_CORR 4'h6
`define TCR_ADDR_PWR 4'h8
`define TCR_ADDR_AGC 4'h9
`define TCR_ADDR_LAST 4'ha
`define TCR_TXRX_BIT 27
`define TCR_SEQ_DIV 27:20
`define TCR_DEMOD_TYPE 5:4
`define TCR_LOCK_COUNT 22:15
`define TCR_LOCK_MODE 25:23
`define TCR_SYNC_WORD 27:4
`define TCR_CAL_BIT 19
`define TCR_REDUCED_GAIN_SELECT_BIT 15
`define TCR_LOGAMP_PD_BIT 10
`define TCR_AGC_LOW 10:4
`define TCR_AGC_HIGH 17:11
`define TCR_AGC_ENABLE_BIT 18
`define TCR_ZERO_WORD 32'h00000000
`define TCR_AGC_RESET 32'h000631e9
`define TCR_AGC_LOW_RESET 7'h1e
`define TCR_AGC_HIGH_RESET 7'h46
`define TCR_SYNC_HOLD_BITS 4'h9
`define TCR_MODE_FREE 3'h0
`define TCR_MODE_SP_LOCK 3'h1
`define TCR_MODE_SYNC_FREE 3'h2
`define TCR_MODE_SYNC_LOCK 3'h3
`define TCR_MODE_PIN 3'h4
`define TCR_MODE_TIMED 3'h5
`define TCR_DEMOD_LINEAR 2'h0
`define TCR_DEMOD_CORR 2'h1
`define TCR_LNA_GAIN_CAP 2'h2
`define TCR_SEQ_ONE 8'h01
`endif

//--- core/tcr_pkg.sv
`default_nettype none
`include "tcr_map.svh"
package tcr_pkg;
  typedef enum logic [1:0] {
    SD_SEARCH = 2'b01,
    SD_HOLD = 2'b10
  } tcr_sync_type;

  typedef struct packed {
    logic [1:0] ceSync;
    logic [1:0] clkSync;
    logic [1:0] dataSync;
    logic [1:0] strobeSync;
    logic clkLast;
    logic strobeLast;
    logic [31:0] shift;
    logic [31:0] word;
    logic wordStrobe;
    logic chipActive;
  } tcr_serial_type;

  typedef struct packed {
    logic [`TCR_NUM_REGS-1:0][31:0] bank;
    logic [23:0] rxBits;
    tcr_sync_type syncState;
    logic [3:0] holdCount;
    logic [7:0] seqCount;
    logic [7:0] lockCount;
    logic [1:0] extLockSync;
    logic demodLocked;
    logic sequencerTick;
    logic lockPinOut;
    logic lockPinOe;
    logic txMode;
    logic antennaTx;
    logic [1:0] demodType;
    logic demodTypeValid;
    logic [2:0] lockMode;
    logic syncDetectEnable;
    logic filterCalStart;
    logic [1:0] lnaGain;
    logic rssiReadbackValid;
    logic auxReadbackValid;
    logic adcReadbackValid;
    logic [6:0] gainLowLimit;
    logic [6:0] gainHighLimit;
  } tcr_core_type;
endpackage : tcr_pkg
`default_nettype wire

//--- core/tcr_serial_port.sv
`default_nettype none
`include "tcr_map.svh"
module tcr_serial_port (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic chipEnable,
  input wire logic serialClock,
  input wire logic serialDataIn,
  input wire logic serialLatchStrobe,
  output logic chipActive,
  output logic wordStrobe,
  output logic [31:0] word
);
  tcr_pkg::tcr_serial_type st;
  tcr_pkg::tcr_serial_type next_st;

  always_comb begin
    next_st = st;
    next_st.ceSync = {st.ceSync[0], chipEnable};
    next_st.clkSync = {st.clkSync[0], serialClock};
    next_st.dataSync = {st.dataSync[0], serialDataIn};
    next_st.strobeSync = {st.strobeSync[0], serialLatchStrobe};
    next_st.clkLast = st.clkSync[1];
    next_st.strobeLast = st.strobeSync[1];
    next_st.chipActive = st.ceSync[1];
    next_st.wordStrobe = 1'b0;
    if (!st.ceSync[1]) begin
      // Port is unpowered: drop any partial word
      next_st.shift = `TCR_ZERO_WORD;
    end else begin
      if (st.clkSync[1] && !st.clkLast) begin
        next_st.shift = {st.shift[30:0], st.dataSync[1]};
      end
      if (st.strobeSync[1] && !st.strobeLast) begin
        next_st.word = st.shift;
        next_st.wordStrobe = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign chipActive = st.chipActive;
  assign wordStrobe = st.wordStrobe;
  assign word = st.word;
endmodule : tcr_serial_port
`default_nettype wire
